// >>> src/scd_regs.vh
// scd_regs.vh: offsets, field positions, reset values for the synth config bank
// assumes inclusion by the config bank and its output gate only
`ifndef SCD_REGS_VH
`define SCD_REGS_VH

// register indices on the byte-wide config port
`define SCD_IDX_FB_HI        4'h0
`define SCD_IDX_FB_LO        4'h1
`define SCD_IDX_REF_DIV      4'h2
`define SCD_IDX_PUMP         4'h3
`define SCD_IDX_EDGE         4'h4
`define SCD_IDX_OUT_EN       4'h5

// field widths
`define SCD_FB_W             12
`define SCD_REF_W            6

// reset values, strap low (16.368 MHz reference)
`define SCD_FB_RST_LO        12'h060
`define SCD_REF_RST_LO       6'h01
// reset values, strap high (19.2 MHz reference)
`define SCD_FB_RST_HI        12'h613
`define SCD_REF_RST_HI       6'h13
// strap independent resets
`define SCD_PUMP_RST         2'h3
`define SCD_EDGE_RST         1'h1
`define SCD_OUT_EN_RST       4'hF

// legal ranges
`define SCD_FB_MIN           12'h038
`define SCD_FB_MAX           12'hFFF
`define SCD_REF_MIN          6'h01
`define SCD_REF_MAX          6'h3F

// output enable bit positions
`define SCD_OE_SAMPLE_CLK    0
`define SCD_OE_DIAG_CLK      1
`define SCD_OE_SIGN          2
`define SCD_OE_AMPLITUDE     3

`endif

// >>> src/scd_out_gate.v
// scd_out_gate.v: forces disabled digital outputs low, never floats them
// assumes enables and data are synchronous to ref_clk
`timescale 1ns/1ps
`include "scd_regs.vh"

module scd_out_gate #(
    parameter N = 4
) (
    // clock
    input  wire         ref_clk,
    input  wire         rst,
    input  wire         clk_en,
    // data
    input  wire [N-1:0] raw_in,
    input  wire [N-1:0] enable,
    output reg  [N-1:0] pin_out
);
    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : g_bit
            always @(posedge ref_clk) begin
                if (rst) begin
                    pin_out[g] <= 1'b0;
                end else if (clk_en) begin
                    // disabled means driven low, no tri-state exists here
                    pin_out[g] <= enable[g] & raw_in[g];
                end
            end
        end
    endgenerate
endmodule // scd_out_gate

// >>> src/scd_config_bank.v
// scd_config_bank.v: synthesizer divider, pump current, edge rate config bank
// assumes a byte-wide write/read port from the serial front end, one clock
`timescale 1ns/1ps
`include "scd_regs.vh"

// Behaviour
// - a 12-bit feedback ratio lives in two byte registers, legal 56..4095, reset 96 or 1555.
// - a 6-bit reference ratio, legal 1..63, resets to 1 or 19 by strap.
// - only a reference ratio write copies both ratios into the active divider vector.
// - a 2-bit pump current code picks 50/100/150/200 uA and resets to 11.
// - one edge-rate bit sets all four digital drivers, 0 fast, 1 slow, reset 1.
// - a disabled digital output is held low, never floated.
// - the strap pin picks both ratio reset values, low for 16.368 MHz, high for 19.2 MHz.
// - a rising device enable while the receive chain is off reloads all defaults.
module scd_config_bank (
    // clock and reset
    input  wire                 ref_clk,
    input  wire                 rst,
    input  wire                 clk_en,
    // pins
    input  wire                 ref_strap,
    input  wire                 device_enable,
    input  wire                 receive_chain_on_pin,
    // config port
    input  wire                 cfg_wr,
    input  wire                 cfg_rd,
    input  wire [3:0]           cfg_addr,
    input  wire [7:0]           cfg_wdata,
    output reg  [7:0]           cfg_rdata,
    output wire                 cfg_bad_value,
    // synthesizer controls
    output reg  [`SCD_FB_W-1:0] active_fb_div,
    output reg  [`SCD_REF_W-1:0] active_ref_div,
    output wire [1:0]           pump_current_sel,
    output wire                 edge_rate_sel,
    // digital outputs
    input  wire                 sample_clock_raw,
    input  wire                 diag_clock_raw,
    input  wire                 sign_raw,
    input  wire                 amplitude_raw,
    output wire                 sample_clock_out,
    output wire                 diag_clock_out,
    output wire                 sign_out,
    output wire                 amplitude_bit_out
);
    // field registers
    reg  [`SCD_FB_W-1:0]  fb_pend_q;
    reg  [`SCD_FB_W-1:0]  fb_pend_d;
    reg  [`SCD_REF_W-1:0] ref_q;
    reg  [1:0]            pump_q;
    reg                   edge_q;
    reg  [3:0]            oe_q;
    reg                   bad_q;
    reg                   bad_d;
    // enable edge detector and readback
    reg                   dev_en_q;
    reg  [7:0]            rdata_d;
    // decoded strobes
    wire                  reload;
    wire                  load_dflt;
    wire                  wr_go;
    wire                  rd_go;
    wire                  wr_fb_hi;
    wire                  wr_fb_lo;
    wire                  wr_ref;
    wire                  wr_pump;
    wire                  wr_edge;
    wire                  wr_oe;
    // strap dependent defaults and range status
    wire [`SCD_FB_W-1:0]  fb_dflt;
    wire [`SCD_REF_W-1:0] ref_dflt;
    wire                  fb_too_low;
    wire                  ref_too_low;
    // output lanes in enable bit order
    wire [3:0]            raw_bus;
    wire [3:0]            pin_bus;

    // strap read live, so defaults follow the pin at the moment of reset or reload
    assign fb_dflt  = ref_strap ? `SCD_FB_RST_HI : `SCD_FB_RST_LO;
    assign ref_dflt = ref_strap ? `SCD_REF_RST_HI : `SCD_REF_RST_LO;

    // loaded with the pin during reset, so a pin already high gives no false edge
    always @(posedge ref_clk) begin
        if (rst || clk_en) begin
            dev_en_q <= device_enable;
        end
    end

    // reload only when the chain is off, so a live receiver keeps its tuning
    assign reload    = device_enable & ~dev_en_q & ~receive_chain_on_pin;
    // reload outranks a write landing in the same cycle
    assign load_dflt = rst | (clk_en & reload);

    // one strobe per register; unmapped indices decode to nothing
    assign wr_go    = clk_en & cfg_wr;
    assign rd_go    = clk_en & cfg_rd;
    assign wr_fb_hi = wr_go & (cfg_addr == `SCD_IDX_FB_HI);
    assign wr_fb_lo = wr_go & (cfg_addr == `SCD_IDX_FB_LO);
    assign wr_ref   = wr_go & (cfg_addr == `SCD_IDX_REF_DIV);
    assign wr_pump  = wr_go & (cfg_addr == `SCD_IDX_PUMP);
    assign wr_edge  = wr_go & (cfg_addr == `SCD_IDX_EDGE);
    assign wr_oe    = wr_go & (cfg_addr == `SCD_IDX_OUT_EN);

    // pending ratio bytes stay apart from the active vector until applied
    always @* begin
        fb_pend_d = fb_pend_q;
        if (wr_fb_hi) begin
            fb_pend_d = {cfg_wdata[3:0], fb_pend_q[7:0]};
        end else if (wr_fb_lo) begin
            fb_pend_d = {fb_pend_q[11:8], cfg_wdata};
        end
    end

    always @(posedge ref_clk) begin
        if (load_dflt) begin
            fb_pend_q <= fb_dflt;
        end else begin
            fb_pend_q <= fb_pend_d;
        end
    end

    // both ratios move together, so the loop never sees half a setting
    always @(posedge ref_clk) begin
        if (load_dflt) begin
            ref_q          <= ref_dflt;
            active_ref_div <= ref_dflt;
            active_fb_div  <= fb_dflt;
        end else if (wr_ref) begin
            ref_q          <= cfg_wdata[5:0];
            active_ref_div <= cfg_wdata[5:0];
            active_fb_div  <= fb_pend_q;
        end
    end

    // out-of-range pair is applied anyway; the flag is the only warning
    assign fb_too_low  = fb_pend_q < `SCD_FB_MIN;
    assign ref_too_low = cfg_wdata[5:0] < `SCD_REF_MIN;

    always @* begin
        bad_d = bad_q;
        if (wr_ref) begin
            bad_d = fb_too_low | ref_too_low;
        end
    end

    always @(posedge ref_clk) begin
        if (load_dflt) begin
            bad_q <= 1'b0;
        end else begin
            bad_q <= bad_d;
        end
    end

    // code steps the pump current in equal quarters of full scale
    always @(posedge ref_clk) begin
        if (load_dflt) begin
            pump_q <= `SCD_PUMP_RST;
        end else if (wr_pump) begin
            pump_q <= cfg_wdata[1:0];
        end
    end

    // one bit for all four drivers, slow edges after reset
    always @(posedge ref_clk) begin
        if (load_dflt) begin
            edge_q <= `SCD_EDGE_RST;
        end else if (wr_edge) begin
            edge_q <= cfg_wdata[0];
        end
    end

    // all outputs come back enabled after reset or reload
    always @(posedge ref_clk) begin
        if (load_dflt) begin
            oe_q <= `SCD_OUT_EN_RST;
        end else if (wr_oe) begin
            oe_q <= cfg_wdata[3:0];
        end
    end

    // ratio bytes read back the pending value, not the active one
    always @* begin
        case (cfg_addr)
            `SCD_IDX_FB_HI:   rdata_d = {4'h0, fb_pend_q[11:8]};
            `SCD_IDX_FB_LO:   rdata_d = fb_pend_q[7:0];
            `SCD_IDX_REF_DIV: rdata_d = {2'h0, ref_q};
            `SCD_IDX_PUMP:    rdata_d = {6'h00, pump_q};
            `SCD_IDX_EDGE:    rdata_d = {7'h00, edge_q};
            `SCD_IDX_OUT_EN:  rdata_d = {4'h0, oe_q};
            default:          rdata_d = 8'h00;
        endcase
    end

    // readback holds until the next read
    always @(posedge ref_clk) begin
        if (rst) begin
            cfg_rdata <= 8'h00;
        end else if (rd_go) begin
            cfg_rdata <= rdata_d;
        end
    end

    assign cfg_bad_value    = bad_q;
    assign pump_current_sel = pump_q;
    assign edge_rate_sel    = edge_q;

    assign raw_bus[`SCD_OE_SAMPLE_CLK] = sample_clock_raw;
    assign raw_bus[`SCD_OE_DIAG_CLK]   = diag_clock_raw;
    assign raw_bus[`SCD_OE_SIGN]       = sign_raw;
    assign raw_bus[`SCD_OE_AMPLITUDE]  = amplitude_raw;
    assign sample_clock_out  = pin_bus[`SCD_OE_SAMPLE_CLK];
    assign diag_clock_out    = pin_bus[`SCD_OE_DIAG_CLK];
    assign sign_out          = pin_bus[`SCD_OE_SIGN];
    assign amplitude_bit_out = pin_bus[`SCD_OE_AMPLITUDE];

    scd_out_gate #(
        .N (4)
    ) u_gate (
        .ref_clk (ref_clk),
        .rst     (rst),
        .clk_en  (clk_en),
        .raw_in  (raw_bus),
        .enable  (oe_q),
        .pin_out (pin_bus)
    );
endmodule // scd_config_bank

// >>> dv/scd_cb_props_properties.sv
// scd_cb_props_properties.sv: port checker for the config bank
// assumes clk_en high and device_enable low across reset
`timescale 1ns/1ps
module scd_cb_props (
    // clock
    input wire        ref_clk,
    input wire        rst,
    input wire        clk_en,
    // pins and port
    input wire        ref_strap,
    input wire        device_enable,
    input wire        receive_chain_on_pin,
    input wire        cfg_wr,
    input wire [3:0]  cfg_addr,
    input wire [7:0]  cfg_wdata,
    // controls
    input wire [11:0] active_fb_div,
    input wire [5:0]  active_ref_div,
    input wire [1:0]  pump_current_sel,
    input wire        edge_rate_sel,
    input wire        sample_clock_out,
    input wire        amplitude_bit_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // a write with the enable low can never meet a reload in the same cycle
    wire wr_go = clk_en && cfg_wr && !device_enable;
    sequence s_ref_wr; wr_go && cfg_addr == 4'h2; endsequence
    sequence s_apply;
        wr_go && cfg_addr == 4'h1 ##1 wr_go && cfg_addr == 4'h0 ##1 s_ref_wr;
    endsequence
    ref_apply_a: assert property (s_ref_wr |=> active_ref_div == $past(cfg_wdata[5:0]))
        else $error("ref ratio not applied");
    fb_apply_a: assert property (s_apply |=> active_fb_div ==
        {$past(cfg_wdata[3:0], 2), $past(cfg_wdata, 3)}) else $error("fb ratio not applied");
    div_hold_a: assert property (!(wr_go && cfg_addr == 4'h2) && !device_enable
        |=> $stable(active_fb_div) && $stable(active_ref_div)) else $error("divider moved");
    reset_vals_a: assert property (disable iff (1'b0) rst && clk_en |=>
        pump_current_sel == 2'h3 && edge_rate_sel && active_fb_div ==
        ($past(ref_strap) ? 12'h613 : 12'h060) && active_ref_div ==
        ($past(ref_strap) ? 6'h13 : 6'h01)) else $error("bad reset values");
    reload_a: assert property ($rose(device_enable) && !receive_chain_on_pin && clk_en
        |=> pump_current_sel == 2'h3 && edge_rate_sel) else $error("no reload");
    pump_wr_a: assert property (wr_go && cfg_addr == 4'h3 && !device_enable
        |=> pump_current_sel == $past(cfg_wdata[1:0])) else $error("pump code lost");
    edge_wr_a: assert property (wr_go && cfg_addr == 4'h4 && !device_enable
        |=> edge_rate_sel == $past(cfg_wdata[0])) else $error("edge bit lost");
    out_low_a: assert property (wr_go && cfg_addr == 4'h5 && cfg_wdata[3:0] == 4'h0
        ##1 !cfg_wr |=> !sample_clock_out && !amplitude_bit_out) else $error("output not low");
endmodule // scd_cb_props
bind scd_config_bank scd_cb_props i_scd_cb_props (.*);

// >>> dv/scd_host_model.sv
// scd_host_model.sv: baseband side driving the byte config port
// assumes every call starts at a falling edge of ref_clk
`timescale 1ns/1ps
module scd_host_model (
    // clock
    input  wire        ref_clk,
    // config port
    output logic       cfg_wr,
    output logic       cfg_rd,
    output logic [3:0] cfg_addr,
    output logic [7:0] cfg_wdata
);
    initial begin
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        cfg_addr = 4'h0;
        cfg_wdata = 8'h00;
    end
    // strobe stays up so writes run back to back
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_wdata = d;
        @(negedge ref_clk);
    endtask
    // released data bus shows no stale value
    task automatic idle();
        cfg_wr = 1'b0;
        cfg_wdata = ~cfg_wdata;
        @(negedge ref_clk);
    endtask
    task automatic rd(input logic [3:0] a);
        cfg_rd = 1'b1;
        cfg_addr = a;
        @(negedge ref_clk);
        cfg_rd = 1'b0;
        @(negedge ref_clk);
    endtask
    // ratio bytes first, reference write last applies both
    task automatic apply(input logic [11:0] f, input logic [5:0] r);
        wr(4'h1, f[7:0]);
        wr(4'h0, {4'h0, f[11:8]});
        wr(4'h2, {2'h0, r});
        idle();
    endtask
endmodule // scd_host_model

// >>> dv/scd_config_bank_bench.sv
// scd_config_bank_bench.sv: self-checking bench for the config bank
// assumes the host model drives the port at falling edges
`timescale 1ns/1ps
module scd_config_bank_bench;
    logic ref_clk, rst, strap, dev_en, chain_on, cfg_wr, cfg_rd, e_sel;
    logic [3:0] cfg_addr, raw;
    wire [3:0] outs;
    wire bad;
    logic [7:0] cfg_wdata, rdata;
    logic [11:0] fb;
    logic [5:0] rdv;
    logic [1:0] pump;
    int n_mismatch = 0;
    int checks_done = 0;
    // rows: index, write data, expected field
    logic [15:0] rows[6] = '{16'h3033, 16'h3022, 16'h3011, 16'h3000, 16'h4011, 16'h4000};
    scd_host_model i_scd_host_model (.ref_clk(ref_clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata));
    scd_config_bank i_scd_config_bank (.ref_clk(ref_clk), .rst(rst), .clk_en(1'b1),
        .ref_strap(strap), .device_enable(dev_en), .receive_chain_on_pin(chain_on),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_rdata(rdata), .cfg_bad_value(bad), .active_fb_div(fb), .active_ref_div(rdv),
        .pump_current_sel(pump), .edge_rate_sel(e_sel), .sample_clock_raw(raw[0]),
        .diag_clock_raw(raw[1]), .sign_raw(raw[2]), .amplitude_raw(raw[3]),
        .sample_clock_out(outs[0]), .diag_clock_out(outs[1]), .sign_out(outs[2]),
        .amplitude_bit_out(outs[3]));
    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic chk_defaults(input logic s);
        chk("fb", s ? 12'd1555 : 12'd96, fb);
        chk("ref", s ? 12'd19 : 12'd1, {6'h0, rdv});
        chk("pump", 12'h3, {10'h0, pump});
        chk("edge", 12'h1, {11'h0, e_sel});
    endtask
    task automatic finish_test();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_mismatch++;
        finish_test();
    end
    initial begin
        {rst, strap, dev_en, chain_on, raw} = 8'h9F;
        repeat (20) @(negedge ref_clk);
        rst = 1'b0;
        chk_defaults(1'b0);
        chk("outs", 12'h0, {8'h0, outs});
        // outputs are registered, one cycle behind the raw data
        @(negedge ref_clk);
        chk("outs", 12'hF, {8'h0, outs});
        foreach (rows[i]) begin
            i_scd_host_model.wr(rows[i][15:12], rows[i][11:4]);
            i_scd_host_model.idle();
            chk("field", rows[i][3:0], rows[i][12] ? {10'h0, pump} : {11'h0, e_sel});
        end
        // pending bytes must not reach the divider before the reference write
        i_scd_host_model.wr(4'h1, 8'hFF);
        i_scd_host_model.wr(4'h0, 8'h0F);
        i_scd_host_model.idle();
        chk("fb", 12'd96, fb);
        i_scd_host_model.wr(4'h2, 8'h3F);
        i_scd_host_model.idle();
        chk("fb", 12'd4095, fb);
        chk("ref", 12'd63, {6'h0, rdv});
        chk("bad", 12'h0, {11'h0, bad});
        i_scd_host_model.apply(12'd55, 6'd1);
        chk("fb", 12'd55, fb);
        chk("bad", 12'h1, {11'h0, bad});
        i_scd_host_model.apply(12'd60, 6'd0);
        chk("bad", 12'h1, {11'h0, bad});
        i_scd_host_model.apply(12'd56, 6'd1);
        chk("fb", 12'd56, fb);
        chk("ref", 12'd1, {6'h0, rdv});
        chk("bad", 12'h0, {11'h0, bad});
        i_scd_host_model.wr(4'h5, 8'h00);
        i_scd_host_model.idle();
        @(negedge ref_clk);
        chk("outs", 12'h0, {8'h0, outs});
        strap = 1'b1;
        dev_en = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk("pump", 12'h0, {10'h0, pump});
        {dev_en, chain_on} = 2'b00;
        @(negedge ref_clk);
        dev_en = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk_defaults(1'b1);
        chk("outs", 12'hF, {8'h0, outs});
        {strap, rst} = 2'b01;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        chk_defaults(1'b0);
        // enable already high at release: a write right away must not be undone
        i_scd_host_model.wr(4'h3, 8'h01);
        i_scd_host_model.idle();
        chk("pump", 12'h1, {10'h0, pump});
        i_scd_host_model.rd(4'h3);
        chk("rdata", 12'h1, {4'h0, rdata});
        i_scd_host_model.rd(4'hF);
        chk("rdata", 12'h0, {4'h0, rdata});
        finish_test();
    end
endmodule // scd_config_bank_bench
